/* src/sbp_buf.sv */
// two-entry buffer with valid and ready on both sides
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps
module sbp_buf #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slot;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               cnt;
  } sbp_buf_state_t;

  sbp_buf_state_t st;
  sbp_buf_state_t next_st;
  logic           push;
  logic           pop;

  // ==========================================
  // pointers and storage
  always_comb begin
    next_st  = st;
    inReady  = (st.cnt != CW'(DEPTH));
    outValid = (st.cnt != '0);
    outData  = st.slot[st.rp];
    push     = inValid & inReady;
    pop      = outValid & outReady;
    if (push) begin
      next_st.slot[st.wp] = inData;
      next_st.wp = (st.wp == PW'(DEPTH - 1)) ? '0 : st.wp + PW'(1);
    end
    if (pop) begin
      next_st.rp = (st.rp == PW'(DEPTH - 1)) ? '0 : st.rp + PW'(1);
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + CW'(1);
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - CW'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  buf_bound_a: assert property (st.cnt <= CW'(DEPTH))
    else $error("buffer count beyond depth");
endmodule : sbp_buf

/* src/sbp_core.sv */
// burst and precharge core of a two-bank synchronous dram
// assumes command, mask and data pins are synchronous to clk_sys
`timescale 1ns/1ps
`include "sbp_map.svh"
module sbp_core #(
  parameter int TRP_CYC = `SBP_TRP_CYC
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire sbp_pkg::sbp_cmd_t cmd,
  input  wire logic             highByteMask,
  input  wire logic             lowByteMask,
  input  wire logic [15:0]      dqIn,
  output logic      [15:0]      dqOut,
  output logic      [15:0]      dqOe,
  input  wire logic [2:0]       burstLenCode,
  input  wire logic             burstInterleave,
  input  wire logic [1:0]       casLatency,
  output logic      [1:0]       bankActive,
  output logic                  wrReady
);
  typedef struct packed {
    sbp_pkg::sbp_bank_t [1:0] bankSt;
    logic [1:0][8:0]          bankRow;
    logic [1:0][3:0]          prCnt;
    logic                     rdBurst;
    logic                     wrBurst;
    logic                     bBank;
    logic                     bAp;
    logic [7:0]               bStart;
    logic [7:0]               bK;
    logic [8:0]               bLen;
    logic [2:0]               rdValid;
    logic [2:0][15:0]         rdData;
    logic [1:0][1:0]          maskDly;
  } sbp_core_state_t;

  sbp_core_state_t       st;
  sbp_core_state_t       next_st;
  logic [15:0]           mem [0:(1 << 18) - 1];
  logic                  isAct;
  logic                  isRd;
  logic                  isWr;
  logic                  isPre;
  logic                  isBst;
  logic                  colBank;
  logic                  rdCmd;
  logic                  wrCmd;
  logic                  burstOn;
  logic [8:0]            len;
  logic                  accBank;
  logic [8:0]            accRow;
  logic [7:0]            accCol;
  logic                  readNow;
  logic                  writeNow;
  logic                  apStart;
  logic                  apBank;
  logic [1:0]            cl;
  logic                  preSlot;
  logic                  drive;
  logic                  pushValid;
  sbp_pkg::sbp_wr_word_t pushWord;
  logic                  drValid;
  logic                  drReady;
  sbp_pkg::sbp_wr_word_t drWord;

  // ==========================================
  // burst column sequence
  function automatic logic [7:0] colAt(input logic [7:0] s, input logic [7:0] k,
                                       input logic [8:0] n, input logic inter);
    logic [7:0] m;
    m = 8'(n - 9'h1);
    if (inter) begin
      colAt = s ^ k;
    end else begin
      colAt = ((s + k) & m) | (s & ~m);
    end
  endfunction : colAt

  // ==========================================
  // command decode
  always_comb begin
    isAct = !cmd.csN & !cmd.rasN & cmd.casN & cmd.weN;
    isRd  = !cmd.csN & cmd.rasN & !cmd.casN & cmd.weN;
    isWr  = !cmd.csN & cmd.rasN & !cmd.casN & !cmd.weN;
    isPre = !cmd.csN & !cmd.rasN & cmd.casN & !cmd.weN;
    isBst = !cmd.csN & cmd.rasN & cmd.casN & !cmd.weN;
    case (burstLenCode)
      `SBP_BL_2:    len = 9'h2;
      `SBP_BL_4:    len = 9'h4;
      `SBP_BL_8:    len = 9'h8;
      `SBP_BL_FULL: len = `SBP_FULL_PAGE_LEN;
      default:      len = 9'h1;
    endcase
    cl = (casLatency == 2'h0) ? 2'h1 : casLatency;
  end

  // ==========================================
  // next state
  always_comb begin
    next_st  = st;
    colBank  = cmd.addr[`SBP_BANK_BIT];
    rdCmd    = isRd & (st.bankSt[colBank] == sbp_pkg::SBP_ACTIVE);
    wrCmd    = isWr & (st.bankSt[colBank] == sbp_pkg::SBP_ACTIVE);
    burstOn  = (st.rdBurst | st.wrBurst) & !rdCmd & !wrCmd & !isBst
             & !(isPre & (cmd.addr[`SBP_AP_BIT] | (cmd.addr[`SBP_BANK_BIT] == st.bBank)));
    accBank  = st.bBank;
    accRow   = st.bankRow[st.bBank];
    accCol   = colAt(st.bStart, st.bK, st.bLen, burstInterleave);
    readNow  = 1'b0;
    writeNow = 1'b0;
    apStart  = 1'b0;
    apBank   = st.bBank;
    if (rdCmd || wrCmd) begin
      // a new column command replaces any running burst
      accBank  = colBank;
      accRow   = st.bankRow[colBank];
      accCol   = cmd.addr[7:0];
      readNow  = rdCmd;
      writeNow = wrCmd;
      next_st.rdBurst = rdCmd;
      next_st.wrBurst = wrCmd;
      next_st.bBank   = colBank;
      next_st.bAp     = cmd.addr[`SBP_AP_BIT] & (len != `SBP_FULL_PAGE_LEN);
      next_st.bStart  = cmd.addr[7:0];
      next_st.bK      = 8'h1;
      next_st.bLen    = len;
      apBank          = colBank;
      if (len == 9'h1) begin
        next_st.rdBurst = 1'b0;
        next_st.wrBurst = 1'b0;
        apStart = next_st.bAp;
      end
    end else if (burstOn) begin
      readNow  = st.rdBurst;
      writeNow = st.wrBurst;
      next_st.bK = st.bK + 8'h1;
      if ((st.bLen != `SBP_FULL_PAGE_LEN) && ({1'b0, st.bK} + 9'h1 == st.bLen)) begin
        next_st.rdBurst = 1'b0;
        next_st.wrBurst = 1'b0;
        apStart = st.bAp;
      end
    end else begin
      next_st.rdBurst = 1'b0;
      next_st.wrBurst = 1'b0;
    end
    next_st.rdValid = {st.rdValid[1:0], readNow};
    next_st.rdData  = {st.rdData[1:0], mem[{accBank, accRow, accCol}]};
    next_st.maskDly = {st.maskDly[0], {highByteMask, lowByteMask}};
    for (int b = 0; b < 2; b++) begin
      case (st.bankSt[b])
        sbp_pkg::SBP_IDLE: begin
          if (isAct && (cmd.addr[`SBP_BANK_BIT] == 1'(b))) begin
            next_st.bankSt[b]  = sbp_pkg::SBP_ACTIVE;
            next_st.bankRow[b] = cmd.addr[8:0];
          end
        end
        sbp_pkg::SBP_ACTIVE: begin
          if ((isPre && (cmd.addr[`SBP_AP_BIT] || cmd.addr[`SBP_BANK_BIT] == 1'(b)))
              || (apStart && apBank == 1'(b))) begin
            next_st.bankSt[b] = sbp_pkg::SBP_PRECH;
            next_st.prCnt[b]  = 4'(TRP_CYC);
          end
        end
        sbp_pkg::SBP_PRECH: begin
          if (st.prCnt[b] <= 4'h1) begin
            next_st.bankSt[b] = sbp_pkg::SBP_IDLE;
          end else begin
            next_st.prCnt[b] = st.prCnt[b] - 4'h1;
          end
        end
        default: next_st.bankSt[b] = sbp_pkg::SBP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================
  // write path through the buffer
  always_comb begin
    pushValid = writeNow & ({highByteMask, lowByteMask} != 2'h3);
    pushWord  = '{bank: accBank, row: accRow, col: accCol,
                  data: dqIn, mask: {highByteMask, lowByteMask}};
    drReady   = !readNow;
  end

  sbp_buf #(
    .WIDTH ($bits(sbp_pkg::sbp_wr_word_t)),
    .DEPTH (2)
  ) u_buf (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .inValid  (pushValid),
    .inReady  (wrReady),
    .inData   (pushWord),
    .outValid (drValid),
    .outReady (drReady),
    .outData  (drWord)
  );

  always_ff @(posedge clk_sys) begin
    if (drValid && drReady) begin
      if (!drWord.mask[0]) begin
        mem[{drWord.bank, drWord.row, drWord.col}][7:0] <= drWord.data[7:0];
      end
      if (!drWord.mask[1]) begin
        mem[{drWord.bank, drWord.row, drWord.col}][15:8] <= drWord.data[15:8];
      end
    end
  end

  // ==========================================
  // read output drivers
  always_comb begin
    preSlot = (cl == 2'h1) ? readNow : st.rdValid[cl - 2'h2];
    drive   = st.rdValid[cl - 2'h1] | preSlot;
    dqOut   = st.rdData[cl - 2'h1];
    dqOe    = {{8{drive & !st.maskDly[1][1]}}, {8{drive & !st.maskDly[1][0]}}};
    bankActive = {st.bankSt[1] == sbp_pkg::SBP_ACTIVE, st.bankSt[0] == sbp_pkg::SBP_ACTIVE};
  end

  // ==========================================
  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  rd_latency_a: assert property (
    (rdCmd && cl == 2'h2 && !highByteMask && !lowByteMask) |-> ##2 (dqOe == 16'hFFFF))
    else $error("read data missing at latency two");
  oe_early_a: assert property (
    (rdCmd && cl == 2'h3 && !highByteMask && !lowByteMask) |-> ##2 (dqOe == 16'hFFFF))
    else $error("drivers not on at latency minus one");
  hiz_idle_a: assert property (
    (st.rdValid == 3'h0 && !readNow) |-> (dqOe == 16'h0000))
    else $error("drivers on without read data");
  rd_mask_a: assert property (
    highByteMask |-> ##2 (dqOe[15:8] == 8'h00))
    else $error("high byte not blanked two clocks after mask");
  wr_push_a: assert property (
    (wrCmd && {highByteMask, lowByteMask} == 2'h3) |-> !pushValid)
    else $error("fully masked write word stored");
  ap_prech_a: assert property (
    (rdCmd && colBank && cmd.addr[8] && burstLenCode == `SBP_BL_4)
      ##1 (!isRd && !isWr && !isPre && !isBst) [*3]
      |=> (st.bankSt[1] == sbp_pkg::SBP_PRECH))
    else $error("auto-precharge did not start after the burst");
  wr_ap_a: assert property (
    (wrCmd && colBank && cmd.addr[8] && burstLenCode == `SBP_BL_4)
      ##1 (!isRd && !isWr && !isPre && !isBst) [*3]
      |=> (st.bankSt[1] == sbp_pkg::SBP_PRECH))
    else $error("write auto-precharge did not start after the last word");
  fp_noap_a: assert property (
    (rdCmd && !colBank && cmd.addr[8] && burstLenCode == `SBP_BL_FULL && !isPre)
      |=> (st.bankSt[0] == sbp_pkg::SBP_ACTIVE))
    else $error("auto-precharge taken in full page");
  pre_both_a: assert property (
    (isPre && cmd.addr[8]) |=> (bankActive == 2'h0))
    else $error("precharge all left a bank active");
  pre_one_a: assert property (
    (isPre && !cmd.addr[8] && cmd.addr[9] && st.bankSt[0] == sbp_pkg::SBP_ACTIVE
      && !(apStart && !apBank)) |=> (st.bankSt[0] == sbp_pkg::SBP_ACTIVE))
    else $error("single bank precharge closed the other bank");
  prech_idle_a: assert property (
    (st.bankSt[1] == sbp_pkg::SBP_PRECH && st.prCnt[1] <= 4'h1)
      |=> (st.bankSt[1] == sbp_pkg::SBP_IDLE))
    else $error("bank did not return to idle after precharge");
  act_row_a: assert property (
    (isAct && !cmd.addr[9] && st.bankSt[0] == sbp_pkg::SBP_IDLE)
      |=> (st.bankSt[0] == sbp_pkg::SBP_ACTIVE && st.bankRow[0] == $past(cmd.addr[8:0])))
    else $error("activate did not open the row");

  rd_burst_c: cover property (rdCmd ##1 burstOn [*3]);
  wr_ap_c: cover property (wrCmd && cmd.addr[8] ##[1:8] apStart);
  rd_over_rd_c: cover property (rdCmd ##1 burstOn ##1 rdCmd);
  rd_mask_c: cover property (rdCmd ##1 lowByteMask);
endmodule : sbp_core

/* src/sbp_map.svh */
// constants for the sdram burst and precharge core
// assumes inclusion by the package and by the core file
`ifndef SBP_MAP_SVH
`define SBP_MAP_SVH
// Functional notes
// - activate and precharge take the bank from bit 9; activate takes the row from 0-8.
// - read and write take column 0-7, auto-precharge on bit 8, bank on bit 9.
// - a full page burst wraps through the 256 columns of the row until it is stopped.
// - read data starts after cas latency, then one word per clock.
// - drivers turn on latency minus one after read, off after the last word.
// - read byte masks blank output two clocks later, whatever the latency.
// - write data is taken on the command cycle, then one word per clock.
// - write bursts end by themselves except in full page mode.
// - write byte masks suppress their byte in the same cycle.
// - read auto-precharge starts latency minus one before the last output word.
// - auto-precharge commands finish the burst, precharge, then leave the bank idle.
// - write auto-precharge starts one clock after the last input word.
// - auto-precharge is ignored in full page mode.
// - a new read replaces the remaining data of a running read.
// - a new write abandons a running write and takes new data at once.
// - precharge with bit 8 low hits the bank of bit 9, high hits both.
// - high mask governs data bits 8-15, low mask bits 0-7, independently.
// - the burst column counter keeps advancing while output is masked.
`define SBP_BANK_BIT 9
`define SBP_AP_BIT 8
`define SBP_FULL_PAGE_LEN 9'h100
`define SBP_BL_1 3'h0
`define SBP_BL_2 3'h1
`define SBP_BL_4 3'h2
`define SBP_BL_8 3'h3
`define SBP_BL_FULL 3'h7
`define SBP_RD_MASK_LAT 2
`define SBP_CLK_NS 8
`define SBP_TRP_NS 20
`define SBP_TRP_CYC ((`SBP_TRP_NS + `SBP_CLK_NS - 1) / `SBP_CLK_NS)
`endif

/* src/sbp_pkg.sv */
// types shared by the core, the bench and the controller model
// assumes the constant header sits beside it
package sbp_pkg;
`include "sbp_map.svh"
  // ==========================================
  // bank and command carriers
  typedef enum logic [1:0] {
    SBP_IDLE   = 2'h0,
    SBP_ACTIVE = 2'h1,
    SBP_PRECH  = 2'h2
  } sbp_bank_t;

  typedef struct packed {
    logic       csN;
    logic       rasN;
    logic       casN;
    logic       weN;
    logic [9:0] addr;
  } sbp_cmd_t;

  typedef struct packed {
    logic        bank;
    logic [8:0]  row;
    logic [7:0]  col;
    logic [15:0] data;
    logic [1:0]  mask;
  } sbp_wr_word_t;
endpackage : sbp_pkg

/* tb/sbp_core_tb_top.sv */
// self-checking bench for the burst and precharge core
// assumes the controller model and the core with its package are compiled first
`timescale 1ns/1ps
`include "sbp_map.svh"
module sbp_core_tb_top;
  localparam logic [3:0] NOP = 4'h7;
  localparam logic [3:0] ACT = 4'h3;
  localparam logic [3:0] RD  = 4'h5;
  localparam logic [3:0] WR  = 4'h4;
  localparam logic [3:0] PRE = 4'h2;
  localparam logic [3:0] BST = 4'h6;
  localparam int         TRP = 3;

  logic              clk_sys;
  logic              sys_rst;
  sbp_pkg::sbp_cmd_t cmd;
  logic              highByteMask;
  logic              lowByteMask;
  logic [15:0]       dqIn;
  logic [15:0]       dqOut;
  logic [15:0]       dqOe;
  logic [2:0]        burstLenCode;
  logic [1:0]        casLatency;
  logic              burstInterleave;
  logic [1:0]        bankActive;
  logic              wrReady;
  logic [15:0]       mem [2][256];
  logic [7:0]        seq = 8'h00;
  int                n_fail = 0;
  int                tests_run = 0;

  sbp_core #(.TRP_CYC(TRP)) u_sbp_core (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd(cmd),
    .highByteMask(highByteMask), .lowByteMask(lowByteMask), .dqIn(dqIn), .dqOut(dqOut),
    .dqOe(dqOe), .burstLenCode(burstLenCode), .burstInterleave(burstInterleave),
    .casLatency(casLatency), .bankActive(bankActive), .wrReady(wrReady));
  sbp_ctrl_model u_sbp_ctrl_model (.clk_sys(clk_sys), .cmd(cmd),
    .highByteMask(highByteMask), .lowByteMask(lowByteMask), .dqIn(dqIn));

  // ==========================================
  // clock and watchdog
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial begin
    #50000;
    n_fail++;
    give_verdict();
  end

  // ==========================================
  // shared helpers
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cy(input logic [3:0] op, input logic [9:0] a = 10'h000,
                    input logic [15:0] d = 16'h0000, input logic [1:0] m = 2'h0,
                    input logic own = 1'h0);
    u_sbp_ctrl_model.drive(op, a, d, m, own);
    #2;
  endtask : cy

  task automatic idle(input int n);
    repeat (n) cy(NOP);
  endtask : idle

  task automatic mode(input logic [2:0] bl, input logic [1:0] cl, input logic il = 1'h0);
    @(posedge clk_sys);
    burstLenCode    <= bl;
    casLatency      <= cl;
    burstInterleave <= il;
    #2;
  endtask : mode

  function automatic logic [7:0] colk(input logic [7:0] col, input int k, input int n);
    logic [7:0] w;
    w = 8'(n - 1);
    if (burstInterleave) return col ^ 8'(k);
    return (col & ~w) | (8'(col + k) & w);
  endfunction : colk

  task automatic wr(input logic b, input logic [7:0] col, input int n, input logic ap,
                    input logic [1:0] m1);
    logic [7:0]  c;
    logic [15:0] d;
    logic [1:0]  m;
    for (int k = 0; k < n; k++) begin
      c = colk(col, k, n);
      seq = seq + 8'h01;
      d = {seq, c};
      m = (k == 1) ? m1 : 2'h0;
      cy(k == 0 ? WR : NOP, {b, ap, col}, d, m, 1'h1);
      if (!m[1]) mem[b][c][15:8] = d[15:8];
      if (!m[0]) mem[b][c][7:0] = d[7:0];
    end
  endtask : wr

  task automatic rd(input logic b, input logic [7:0] col, input int n, input int cl,
                    input logic ap, input int mc);
    logic [15:0] e;
    int          c;
    cy(RD, {b, ap, col});
    for (int j = 1; j <= cl + n + 1; j++) begin
      cy(NOP, 10'h000, 16'h0000, {1'h0, j == mc});
      c = j;
      if (c == cl - 1) chk(dqOe, 16'hFFFF);
      if (c >= cl && c < cl + n) begin
        e = mem[b][colk(col, c - cl, n)];
        if (c == mc + 2) begin
          chk(dqOe, 16'hFF00);
          chk({dqOut[15:8], 8'h00}, {e[15:8], 8'h00});
        end else begin
          chk(dqOut, e);
        end
      end
      if (c == cl + n) chk(dqOe, 16'h0000);
      if (ap && c == n - 1) chk({15'h0000, bankActive[b]}, 16'h0001);
      if (ap && c == n) chk({15'h0000, bankActive[b]}, 16'h0000);
    end
  endtask : rd

  // ==========================================
  // scenarios
  task automatic s_open();
    chk({15'h0000, wrReady}, 16'h0001);
    cy(ACT, {1'h0, 9'h012});
    cy(ACT, {1'h1, 9'h134});
    chk({14'h0000, bankActive}, 16'h0001);
    cy(NOP);
    chk({14'h0000, bankActive}, 16'h0003);
  endtask : s_open

  task automatic s_rw();
    mode(`SBP_BL_8, 2'h2);
    wr(1'h0, 8'h00, 8, 1'h0, 2'h0);
    idle(4);
    mode(`SBP_BL_4, 2'h2);
    rd(1'h0, 8'h05, 4, 2, 1'h0, -1);
    mode(`SBP_BL_4, 2'h3);
    rd(1'h0, 8'h02, 4, 3, 1'h0, -1);
    mode(`SBP_BL_4, 2'h2, 1'h1);
    rd(1'h0, 8'h05, 4, 2, 1'h0, -1);
  endtask : s_rw

  task automatic s_mask();
    mode(`SBP_BL_4, 2'h2);
    wr(1'h0, 8'h01, 4, 1'h0, 2'h2);
    idle(4);
    rd(1'h0, 8'h01, 4, 2, 1'h0, 1);
  endtask : s_mask

  task automatic s_cut();
    wr(1'h0, 8'h10, 1, 1'h0, 2'h0);
    wr(1'h0, 8'h14, 4, 1'h0, 2'h0);
    idle(4);
    cy(RD, {2'h0, 8'h10});
    rd(1'h0, 8'h14, 4, 2, 1'h0, -1);
  endtask : s_cut

  task automatic s_auto();
    wr(1'h1, 8'h20, 4, 1'h1, 2'h0);
    chk({15'h0000, bankActive[1]}, 16'h0001);
    cy(NOP);
    chk({15'h0000, bankActive[1]}, 16'h0000);
    cy(NOP);
    chk({15'h0000, bankActive[1]}, 16'h0000);
    cy(ACT, 10'h334);
    cy(NOP);
    chk({15'h0000, bankActive[1]}, 16'h0000);
    cy(ACT, 10'h334);
    cy(NOP);
    chk({15'h0000, bankActive[1]}, 16'h0001);
    idle(2);
    rd(1'h1, 8'h20, 4, 2, 1'h1, -1);
  endtask : s_auto

  task automatic s_full();
    mode(`SBP_BL_FULL, 2'h2);
    wr(1'h0, 8'h00, 256, 1'h0, 2'h0);
    cy(BST);
    idle(4);
    cy(RD, {2'h0, 8'h00});
    for (int j = 1; j <= 261; j++) begin
      cy(j == 258 ? BST : NOP);
      if (j >= 2 && j <= 259) chk(dqOut, mem[0][8'(j - 2)]);
    end
    chk(dqOe, 16'h0000);
    cy(RD, {2'h1, 8'h00});
    cy(BST);
    idle(3);
    chk({15'h0000, bankActive[0]}, 16'h0001);
  endtask : s_full

  task automatic s_pre();
    cy(ACT, {1'h1, 9'h055});
    idle(4);
    cy(PRE, 10'h200);
    idle(2);
    chk({14'h0000, bankActive}, 16'h0001);
    cy(PRE, 10'h300);
    idle(2);
    chk({14'h0000, bankActive}, 16'h0000);
  endtask : s_pre

  // ==========================================
  // main sequence
  initial begin
    sys_rst      = 1'h1;
    burstLenCode = `SBP_BL_4;
    casLatency   = 2'h2;
    burstInterleave = 1'h0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'h0;
    s_open();
    s_rw();
    s_mask();
    s_cut();
    s_auto();
    s_full();
    s_pre();
    give_verdict();
  end
endmodule : sbp_core_tb_top

/* tb/sbp_ctrl_model.sv */
// controller model driving command, byte mask and write data pins of the core
// assumes one drive call per clock, made by the bench just after a rising edge
`timescale 1ns/1ps
module sbp_ctrl_model (
  input  wire logic         clk_sys,
  output sbp_pkg::sbp_cmd_t cmd,
  output logic              highByteMask,
  output logic              lowByteMask,
  output logic [15:0]       dqIn
);
  // ==========================================
  // bank bookkeeping and idle pins
  logic [1:0] opened = 2'h0;

  initial begin
    cmd          = {4'hF, 10'h000};
    highByteMask = 1'h0;
    lowByteMask  = 1'h0;
    dqIn         = 16'h0000;
  end

  // ==========================================
  // one command cycle, one command per clock
  task automatic drive(input logic [3:0] op, input logic [9:0] a, input logic [15:0] d,
                       input logic [1:0] m, input logic own);
    if ((op == 4'h5 || op == 4'h4) && !opened[a[9]]) op = 4'h7;
    if (op == 4'h3) opened[a[9]] = 1'h1;
    if (op == 4'h2) opened = a[8] ? 2'h0 : (opened & ~(2'h1 << a[9]));
    @(posedge clk_sys);
    cmd <= {op, a};
    dqIn <= own ? d : ~dqIn;
    {highByteMask, lowByteMask} <= m;
  endtask : drive
endmodule : sbp_ctrl_model
